//--- design/owr_cfg.svh
/*
 Timing, command and reset constants for the single-wire read-slot link.
 Assumes a 10 MHz system clock on both ends; times are in microseconds.
*/
`ifndef OWR_CFG_SVH
`define OWR_CFG_SVH

`define OWR_CLK_MHZ      10
`define OWR_CYC(us)      ((us) * `OWR_CLK_MHZ)

`define OWR_T_INIT_US    1
`define OWR_T_REC_US     1
`define OWR_T_SLOT_US    60
`define OWR_T_SAMPLE_US  13
`define OWR_T_VALID_US   15
`define OWR_T_WSAMP_US   30
`define OWR_T_RST_US     480
`define OWR_T_RSTDET_US  400
`define OWR_T_PSAMP_US   70
`define OWR_T_PWAIT_US   30
`define OWR_T_PRES_US    120
`define OWR_CONVERSION_DURATION_US    750000
`define OWR_T_RECALL_US  100

`define OWR_CMD_MATCH    8'h55
`define OWR_CMD_SKIP     8'hCC
`define OWR_CMD_CONV     8'h44
`define OWR_CMD_RDSP     8'hBE
`define OWR_CMD_RECALL   8'hB8
`define OWR_CMD_PSUP     8'hB4

`define OWR_CRC_POLY     8'h8C
`define OWR_TH_RST       8'h4B
`define OWR_TL_RST       8'h46
`define OWR_PAD_BYTE     8'hFF
`define OWR_CNT_PER_DEG  8'h10
`define OWR_SP_BITS      72
`define OWR_ROM_BITS     64

`endif

//--- design/owr_if.sv
/*
 Open-drain single wire between one master and one sensor, plus the
 master's strong pullup control. Assumes a pullup: the line is high
 unless an end drives it low (enable low means driving).
*/
interface owr_if;
	logic m_dq_o;
	logic m_dq_oe_n;
	logic s_dq_o;
	logic s_dq_oe_n;
	logic spu;
	logic dq;

	assign dq = ~((~m_dq_oe_n & ~m_dq_o) | (~s_dq_oe_n & ~s_dq_o));

	modport master (output m_dq_o, output m_dq_oe_n, output spu, input dq);
	modport sensor (output s_dq_o, output s_dq_oe_n, input spu, input dq);
endinterface

//--- design/owr_master.sv
/*
 Link master: reset/presence, addressing, conversion under strong pullup,
 scratchpad read with CRC check and retry, result FIFO toward the user.
 Assumes one synchronous 10 MHz clock and the wire level from owr_if.
*/
`include "owr_cfg.svh"

module owr_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	logic          push;
	logic          pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_reg[rd_reg];
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge mclk) begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_next;
			in_ready <= (cnt_next != (AW+1)'(D));
			out_valid <= (cnt_next != '0);
		end
	end
endmodule

// Function
// R1: sensor talks only inside master-opened slots
// R2: read slots follow read command at once
// R3: status poll slots after convert or recall
// R4: poll answer 0 busy, 1 finished
// R5: slot at least 60us, 1us recovery
// R6: slot opens with low of 1us
// R7: one released, zero held low
// R8: sensor releases zero before slot end
// R9: sensor bit valid 15us after fall
// R10: master samples within 15us of fall
// R11: short low, late sample recommended
// R12: reset then presence opens each transaction
// R13: select command plus 64-bit identifier
// R14: strong pullup for whole conversion
// R15: nine bytes, CRC of first eight
// R16: CRC mismatch repeats whole read
// R17: bytes travel lsb first
// R18: presence 15-60us wait, 60-240us low
// R19: no presence flags error, stops
// R20: first sampled bit lands in lsb
module owr_master #(
	parameter int RST_CYC  = `OWR_CYC(`OWR_T_RST_US),
	parameter int CONV_CYC = `OWR_CYC(`OWR_CONVERSION_DURATION_US),
	parameter int FW       = 8,
	parameter int FD       = 16
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	owr_if.master              bus,
	input  wire logic          cmd_valid,
	input  owr_pkg::owr_op_e   cmd_op,
	input  wire logic          cmd_match,
	input  wire logic [63:0]   cmd_rom,
	output logic               cmd_ready,
	output logic               done,
	output logic               err,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [FW-1:0]      out_data
);
	localparam logic [23:0] INIT_C = 24'(`OWR_CYC(`OWR_T_INIT_US));
	localparam logic [23:0] LOW0_C = 24'(`OWR_CYC(`OWR_T_SLOT_US));
	localparam logic [23:0] SLOT_C =
		24'(`OWR_CYC(`OWR_T_SLOT_US + `OWR_T_REC_US));
	localparam logic [23:0] SAMP_C = 24'(`OWR_CYC(`OWR_T_SAMPLE_US));
	localparam logic [23:0] PSMP_C = 24'(`OWR_CYC(`OWR_T_PSAMP_US));

	owr_pkg::owr_mst_e st_reg;
	owr_pkg::owr_op_e  op_reg;
	logic                    match_reg;
	logic [63:0]             rom_reg;
	logic [23:0]             tmr_reg;
	logic                    pres_reg;
	logic [3:0]              bi_reg;
	logic [2:0]              bc_reg;
	logic [6:0]              rb_reg;
	logic [`OWR_SP_BITS-1:0] rx_reg;
	logic [7:0]              crc_reg;
	logic [3:0]              pi_reg;
	logic [7:0]              tx_byte;
	logic [23:0]             low_len;
	logic                    drv;
	logic                    slot_end;
	logic                    f_ready;

	always_comb begin
		tx_byte = op_reg == owr_pkg::OWR_OP_CONV ? `OWR_CMD_CONV : `OWR_CMD_RDSP;
		if (bi_reg == 4'h0)
			tx_byte = match_reg ? `OWR_CMD_MATCH : `OWR_CMD_SKIP; // R13
		else if (bi_reg != 4'h9)
			tx_byte = rom_reg[8*(bi_reg-4'h1) +: 8]; // R13
	end

	// a one bit uses the short opening low, a zero holds the whole slot
	always_comb begin
		low_len = INIT_C; // R6 R11
		if (st_reg == owr_pkg::OWM_TX && !tx_byte[bc_reg]) // R17
			low_len = LOW0_C;
	end

	assign slot_end = tmr_reg == SLOT_C - 24'h1; // R5
	assign drv = st_reg == owr_pkg::OWM_RSTL ||
		((st_reg == owr_pkg::OWM_TX || st_reg == owr_pkg::OWM_RX) &&
		 tmr_reg < low_len);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus.m_dq_oe_n <= 1'b1;
			bus.m_dq_o <= 1'b0;
			bus.spu <= 1'b0;
		end else begin
			bus.m_dq_oe_n <= ~drv;
			bus.m_dq_o <= 1'b0;
			bus.spu <= st_reg == owr_pkg::OWM_SPU; // R14
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= owr_pkg::OWM_IDLE;
			op_reg <= owr_pkg::OWR_OP_CONV;
			match_reg <= 1'b0;
			rom_reg <= '0;
			tmr_reg <= '0;
			pres_reg <= 1'b0;
			bi_reg <= '0;
			bc_reg <= '0;
			rb_reg <= '0;
			rx_reg <= '0;
			crc_reg <= '0;
			pi_reg <= '0;
			done <= 1'b0;
			err <= 1'b0;
			cmd_ready <= 1'b1;
		end else begin
			done <= 1'b0;
			tmr_reg <= tmr_reg + 24'h1;
			case (st_reg)
			owr_pkg::OWM_IDLE: begin
				tmr_reg <= '0;
				if (cmd_valid) begin
					op_reg <= cmd_op;
					match_reg <= cmd_match;
					rom_reg <= cmd_rom;
					err <= 1'b0;
					cmd_ready <= 1'b0;
					st_reg <= owr_pkg::OWM_RSTL; // R12
				end
			end
			owr_pkg::OWM_RSTL: begin
				if (tmr_reg == 24'(RST_CYC - 1)) begin
					tmr_reg <= '0;
					pres_reg <= 1'b0;
					st_reg <= owr_pkg::OWM_RSTW;
				end
			end
			owr_pkg::OWM_RSTW: begin
				if (tmr_reg == PSMP_C && !bus.dq)
					pres_reg <= 1'b1; // R12
				if (tmr_reg == 24'(RST_CYC - 1)) begin
					tmr_reg <= '0;
					bi_reg <= '0;
					bc_reg <= '0;
					if (!pres_reg) begin
						err <= 1'b1; // R19
						cmd_ready <= 1'b1;
						st_reg <= owr_pkg::OWM_IDLE;
					end else
						st_reg <= owr_pkg::OWM_TX;
				end
			end
			owr_pkg::OWM_TX: begin
				if (slot_end) begin
					tmr_reg <= '0;
					bc_reg <= bc_reg + 3'h1; // R17
					if (bc_reg == 3'h7) begin
						if (bi_reg == 4'h9) begin
							rb_reg <= '0;
							crc_reg <= '0;
							st_reg <= op_reg == owr_pkg::OWR_OP_CONV ?
								owr_pkg::OWM_SPU :
								owr_pkg::OWM_RX; // R2 R14
						end else if (bi_reg == 4'h0 && !match_reg)
							bi_reg <= 4'h9;
						else
							bi_reg <= bi_reg + 4'h1;
					end
				end
			end
			owr_pkg::OWM_RX: begin
				if (tmr_reg == SAMP_C) begin
					rx_reg <= {bus.dq, rx_reg[`OWR_SP_BITS-1:1]}; // R10 R20
					if (rb_reg < 7'(`OWR_ROM_BITS))
						crc_reg <= owr_pkg::owr_crc_step(crc_reg, bus.dq); // R15
				end
				if (slot_end) begin
					tmr_reg <= '0;
					rb_reg <= rb_reg + 7'h1;
					if (rb_reg == 7'(`OWR_SP_BITS - 1))
						st_reg <= owr_pkg::OWM_CHK;
				end
			end
			owr_pkg::OWM_CHK: begin
				tmr_reg <= '0;
				pi_reg <= '0;
				if (crc_reg == rx_reg[`OWR_SP_BITS-1 -: 8]) // R15
					st_reg <= owr_pkg::OWM_PUSH;
				else
					st_reg <= owr_pkg::OWM_RSTL; // R16
			end
			owr_pkg::OWM_PUSH: begin
				if (f_ready) begin
					pi_reg <= pi_reg + 4'h1;
					if (pi_reg == 4'h8) begin
						done <= 1'b1;
						cmd_ready <= 1'b1;
						st_reg <= owr_pkg::OWM_IDLE;
					end
				end
			end
			owr_pkg::OWM_SPU: begin
				if (tmr_reg == 24'(CONV_CYC - 1)) begin // R14
					done <= 1'b1;
					cmd_ready <= 1'b1;
					st_reg <= owr_pkg::OWM_IDLE;
				end
			end
			default: st_reg <= owr_pkg::OWM_IDLE;
			endcase
		end
	end

	// all nine bytes pass the check before any enters the fifo
	owr_fifo #(.W(FW), .D(FD)) u_fifo (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.in_valid  (st_reg == owr_pkg::OWM_PUSH),
		.in_ready  (f_ready),
		.in_data   (FW'(rx_reg[8*pi_reg +: 8])),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);
endmodule

//--- design/owr_pkg.sv
/*
 Shared types of the single-wire link: operations, state codes, CRC step.
 Assumes owr_cfg.svh is on the include path.
*/
`include "owr_cfg.svh"

package owr_pkg;

	typedef enum logic [0:0] {
		OWR_OP_CONV = 1'b0,
		OWR_OP_READ = 1'b1
	} owr_op_e;

	typedef enum logic [7:0] {
		OWM_IDLE = 8'h01,
		OWM_RSTL = 8'h02,
		OWM_RSTW = 8'h04,
		OWM_TX   = 8'h08,
		OWM_RX   = 8'h10,
		OWM_SPU  = 8'h20,
		OWM_CHK  = 8'h40,
		OWM_PUSH = 8'h80
	} owr_mst_e;

	typedef enum logic [8:0] {
		OWS_IDLE  = 9'h001,
		OWS_PWAIT = 9'h002,
		OWS_PRES  = 9'h004,
		OWS_ROM   = 9'h008,
		OWS_MATCH = 9'h010,
		OWS_FUNC  = 9'h020,
		OWS_READ  = 9'h040,
		OWS_POLL  = 9'h080,
		OWS_PSUP  = 9'h100
	} owr_snr_e;

	// reflected CRC-8, one bit per call, data taken lsb first
	function automatic logic [7:0] owr_crc_step(input logic [7:0] c,
						    input logic b);
		owr_crc_step = {1'b0, c[7:1]} ^ ((c[0] ^ b) ? `OWR_CRC_POLY : 8'h00);
	endfunction

endpackage

//--- design/owr_sensor.sv
/*
 Sensor end: reset detect and presence, identifier select, conversion and
 recall status polling, scratchpad read-out with CRC, supply query.
 Assumes the wire level is synchronous to mclk; sensor is self-powered.
*/
`include "owr_cfg.svh"

module owr_sensor #(
	parameter logic [63:0] ROM_ID     = 64'h5A00_0000_0000_0A28,
	parameter int          CONV_CYC   = `OWR_CYC(`OWR_CONVERSION_DURATION_US),
	parameter int          RECALL_CYC = `OWR_CYC(`OWR_T_RECALL_US)
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	owr_if.sensor            bus,
	input  wire logic [15:0] temp_in,
	input  wire logic [7:0]  remain_in,
	output logic             selected,
	output logic             conv_busy
);
	// ROM_ID default is arbitrary
	localparam logic [11:0] HOLD_C = 12'(`OWR_CYC(`OWR_T_VALID_US));
	localparam logic [11:0] WSMP_C = 12'(`OWR_CYC(`OWR_T_WSAMP_US));
	localparam logic [11:0] PWT_C = 12'(`OWR_CYC(`OWR_T_PWAIT_US));
	localparam logic [11:0] PRS_C = 12'(`OWR_CYC(`OWR_T_PRES_US));
	localparam logic [12:0] RDET_C = 13'(`OWR_CYC(`OWR_T_RSTDET_US));

	owr_pkg::owr_snr_e st_reg;
	logic                    dq_q;
	logic [12:0]             low_reg;
	logic [11:0]             tmr_reg;
	logic [2:0]              bc_reg;
	logic [7:0]              rxb_reg;
	logic [5:0]              mc_reg;
	logic                    mis_reg;
	logic [6:0]              tb_reg;
	logic [`OWR_ROM_BITS-1:0] sp_reg;
	logic [7:0]              crc_reg;
	logic [7:0]              th_reg;
	logic [7:0]              tl_reg;
	logic [23:0]             busy_reg;
	logic                    fall;
	logic                    rst_seen;
	logic                    wbit;
	logic                    rx_done;
	logic [7:0]              rx_byte;
	logic                    tx_bit;

	assign fall = dq_q & ~bus.dq;
	assign rst_seen = ~dq_q & bus.dq & (low_reg >= RDET_C);
	assign wbit = tmr_reg == WSMP_C && !fall;
	assign rx_done = wbit && bc_reg == 3'h7;
	assign rx_byte = {bus.dq, rxb_reg[7:1]};

	always_comb begin
		tx_bit = 1'b1; // R7
		case (st_reg)
		owr_pkg::OWS_READ: tx_bit = tb_reg < 7'(`OWR_ROM_BITS) ?
			sp_reg[tb_reg[5:0]] : crc_reg[0]; // R15 R17
		owr_pkg::OWS_POLL: tx_bit = busy_reg == '0; // R3 R4
		default: tx_bit = 1'b1;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dq_q <= 1'b1;
			low_reg <= '0;
			tmr_reg <= '0;
		end else begin
			dq_q <= bus.dq;
			low_reg <= bus.dq ? '0 : (&low_reg ? low_reg : low_reg + 13'h1);
			if (fall || rst_seen)
				tmr_reg <= '0;
			else if (!(&tmr_reg))
				tmr_reg <= tmr_reg + 12'h1;
		end
	end

	// drive only as a reply to a master fall or a detected reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus.s_dq_oe_n <= 1'b1;
			bus.s_dq_o <= 1'b0;
		end else begin
			bus.s_dq_o <= 1'b0;
			if (rst_seen)
				bus.s_dq_oe_n <= 1'b1;
			else if (st_reg == owr_pkg::OWS_PWAIT && tmr_reg == PWT_C - 12'h1)
				bus.s_dq_oe_n <= 1'b0; // R18
			else if (st_reg == owr_pkg::OWS_PRES && tmr_reg == PRS_C - 12'h1)
				bus.s_dq_oe_n <= 1'b1; // R18
			else if (fall && !tx_bit && !bus.spu)
				bus.s_dq_oe_n <= 1'b0; // R1 R7
			else if (st_reg != owr_pkg::OWS_PRES && tmr_reg == HOLD_C - 12'h1)
				bus.s_dq_oe_n <= 1'b1; // R8 R9
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_reg <= '0;
			conv_busy <= 1'b0;
			th_reg <= `OWR_TH_RST;
			tl_reg <= `OWR_TL_RST;
		end else begin
			if (busy_reg != '0)
				busy_reg <= busy_reg - 24'h1;
			conv_busy <= busy_reg > 24'h1;
			if (st_reg == owr_pkg::OWS_FUNC && rx_done) begin
				if (rx_byte == `OWR_CMD_CONV) begin
					busy_reg <= 24'(CONV_CYC);
					conv_busy <= 1'b1;
				end else if (rx_byte == `OWR_CMD_RECALL) begin
					busy_reg <= 24'(RECALL_CYC);
					th_reg <= `OWR_TH_RST;
					tl_reg <= `OWR_TL_RST;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= owr_pkg::OWS_IDLE;
			bc_reg <= '0;
			rxb_reg <= '0;
			mc_reg <= '0;
			mis_reg <= 1'b0;
			tb_reg <= '0;
			sp_reg <= '0;
			crc_reg <= '0;
			selected <= 1'b0;
		end else if (rst_seen) begin
			st_reg <= owr_pkg::OWS_PWAIT; // R12 R18
			bc_reg <= '0;
			selected <= 1'b0;
		end else begin
			if (wbit) begin
				bc_reg <= bc_reg + 3'h1;
				rxb_reg <= rx_byte; // R17
			end
			case (st_reg)
			owr_pkg::OWS_PWAIT:
				if (tmr_reg == PWT_C - 12'h1)
					st_reg <= owr_pkg::OWS_PRES;
			owr_pkg::OWS_PRES: begin
				bc_reg <= '0;
				if (tmr_reg == PRS_C - 12'h1)
					st_reg <= owr_pkg::OWS_ROM;
			end
			owr_pkg::OWS_ROM:
				if (rx_done) begin
					mc_reg <= '0;
					mis_reg <= 1'b0;
					if (rx_byte == `OWR_CMD_MATCH)
						st_reg <= owr_pkg::OWS_MATCH;
					else if (rx_byte == `OWR_CMD_SKIP) begin
						selected <= 1'b1;
						st_reg <= owr_pkg::OWS_FUNC;
					end else
						st_reg <= owr_pkg::OWS_IDLE;
				end
			owr_pkg::OWS_MATCH:
				if (wbit) begin
					mc_reg <= mc_reg + 6'h1;
					if (bus.dq != ROM_ID[mc_reg])
						mis_reg <= 1'b1;
					if (mc_reg == 6'h3F) begin
						if (mis_reg || bus.dq != ROM_ID[mc_reg])
							st_reg <= owr_pkg::OWS_IDLE;
						else begin
							selected <= 1'b1;
							st_reg <= owr_pkg::OWS_FUNC;
						end
					end
				end
			owr_pkg::OWS_FUNC:
				if (rx_done) begin
					tb_reg <= '0;
					crc_reg <= '0;
					sp_reg <= {`OWR_CNT_PER_DEG, remain_in, `OWR_PAD_BYTE,
						   `OWR_PAD_BYTE, tl_reg, th_reg, temp_in};
					case (rx_byte)
					`OWR_CMD_CONV: st_reg <= owr_pkg::OWS_POLL;
					`OWR_CMD_RECALL: st_reg <= owr_pkg::OWS_POLL;
					`OWR_CMD_RDSP: st_reg <= owr_pkg::OWS_READ;
					`OWR_CMD_PSUP: st_reg <= owr_pkg::OWS_PSUP;
					default: st_reg <= owr_pkg::OWS_IDLE;
					endcase
				end
			owr_pkg::OWS_READ:
				if (fall) begin
					tb_reg <= tb_reg + 7'h1;
					crc_reg <= tb_reg < 7'(`OWR_ROM_BITS) ?
						owr_pkg::owr_crc_step(crc_reg, tx_bit) :
						{1'b0, crc_reg[7:1]}; // R15
					if (tb_reg == 7'(`OWR_SP_BITS - 1))
						st_reg <= owr_pkg::OWS_IDLE;
				end
			owr_pkg::OWS_POLL: st_reg <= owr_pkg::OWS_POLL;
			owr_pkg::OWS_PSUP:
				if (fall)
					st_reg <= owr_pkg::OWS_IDLE;
			owr_pkg::OWS_IDLE: st_reg <= owr_pkg::OWS_IDLE;
			default: st_reg <= owr_pkg::OWS_IDLE;
			endcase
		end
	end
endmodule

//--- sim/onewire_read_slot_transactions_tb.sv
/*
 Testbench: conversion and scratchpad read between master and sensor,
 a master alone on a silent line, and the result FIFO drained at full rate.
 Assumes the design files and the checker are compiled before it.
*/
module onewire_read_slot_transactions_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int          CONV   = 2000;
	localparam logic [15:0] TEMP   = 16'h0132;
	localparam logic [7:0]  REMAIN = 8'h0C;
	logic              mclk = 1'b0;
	logic              reset_n = 1'b0;
	logic              cmd_valid = 1'b0;
	logic              cmd_valid_b = 1'b0;
	owr_pkg::owr_op_e  cmd_op = owr_pkg::OWR_OP_CONV;
	logic              cmd_match = 1'b0;
	logic [63:0]       cmd_rom = 64'h0;
	logic              out_ready = 1'b0;
	logic              cmd_ready, done, err, out_valid, sel, conv_busy;
	logic              done_b, err_b, out_valid_b, cmd_ready_b;
	logic [7:0]        out_data;
	logic [7:0]        res_exp[9];
	logic              bits_q[$];
	int                spu_cycles = 0;
	int                fall_b = 0;
	int                num_errors = 0;
	int                check_count = 0;

	owr_if bus_a ();
	owr_if bus_b ();
	// nobody answers on the second line
	assign bus_b.s_dq_oe_n = 1'b1;
	assign bus_b.s_dq_o = 1'b1;

	always #50 mclk = ~mclk;

	owr_master #(.CONV_CYC(CONV)) u_owr_master (.mclk(mclk),
		.reset_n(reset_n), .bus(bus_a), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_match(cmd_match), .cmd_rom(cmd_rom),
		.cmd_ready(cmd_ready), .done(done), .err(err),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
	owr_sensor #(.CONV_CYC(CONV)) u_owr_sensor (.mclk(mclk),
		.reset_n(reset_n), .bus(bus_a), .temp_in(TEMP),
		.remain_in(REMAIN), .selected(sel), .conv_busy(conv_busy));
	owr_master #(.CONV_CYC(CONV)) u_owr_master_b (.mclk(mclk),
		.reset_n(reset_n), .bus(bus_b), .cmd_valid(cmd_valid_b),
		.cmd_op(cmd_op), .cmd_match(cmd_match), .cmd_rom(cmd_rom),
		.cmd_ready(cmd_ready_b), .done(done_b), .err(err_b),
		.out_valid(out_valid_b), .out_ready(1'b1), .out_data());
	owr_link_checker #(.CONV_CYC(CONV)) u_owr_link_checker (.mclk(mclk),
		.reset_n(reset_n), .m_dq_o(bus_a.m_dq_o),
		.m_dq_oe_n(bus_a.m_dq_oe_n), .s_dq_o(bus_a.s_dq_o),
		.s_dq_oe_n(bus_a.s_dq_oe_n), .spu(bus_a.spu), .dq(bus_a.dq));

	// line level 30us after each master fall, as a sensor would read it
	always begin
		@(negedge bus_a.m_dq_oe_n);
		repeat (300) @(posedge mclk);
		bits_q.push_back(bus_a.dq);
	end
	always @(negedge bus_b.m_dq_oe_n) fall_b++;
	// counted mid-cycle, away from the edge that launches the pullup
	always @(negedge mclk) if (bus_a.spu === 1'b1) spu_cycles++;

	task automatic chk(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic issue(input owr_pkg::owr_op_e op);
		@(posedge mclk);
		#5;
		bits_q.delete();
		cmd_op = op;
		cmd_valid = 1'b1;
		@(posedge mclk);
		#5;
		cmd_valid = 1'b0;
	endtask

	task automatic wait_done(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge mclk);
			#1;
			if (done === 1'b1) break;
		end
		chk("done", 1, done);
	endtask

	// slot 0 is the reset pulse; then skip command and function byte
	task automatic chk_cmd(input logic [7:0] fn);
		logic [7:0] b0, b1;
		for (int i = 0; i < 8; i++) begin
			b0[i] = bits_q[1 + i];
			b1[i] = bits_q[9 + i];
		end
		chk("rom command", 8'hCC, b0);
		chk("function command", fn, b1);
	endtask

	task automatic conversion_duration();
		spu_cycles = 0;
		issue(owr_pkg::OWR_OP_CONV);
		wait_done(25000);
		// pullup drops one edge after done
		@(posedge mclk);
		#5;
		chk("error flag", 0, err);
		chk("sensor selected", 1, sel);
		chk("pullup cycles", CONV, spu_cycles);
		chk("conversion busy", 0, conv_busy);
		chk("slot count", 17, bits_q.size());
		chk_cmd(8'h44);
		$display("test conversion finished");
	endtask

	task automatic t_lone();
		@(posedge mclk);
		#5;
		cmd_valid_b = 1'b1;
		@(posedge mclk);
		#5;
		cmd_valid_b = 1'b0;
		// an abandoned transaction raises err, not done
		for (int i = 0; i < 12000; i++) begin
			@(posedge mclk);
			#1;
			if (err_b === 1'b1) break;
		end
		chk("lone ready", 1, cmd_ready_b);
		chk("lone no done", 0, done_b);
		chk("lone error", 1, err_b);
		chk("lone falls", 1, fall_b);
		chk("lone output", 0, out_valid_b);
		$display("test silent line finished");
	endtask

	task automatic t_read();
		logic [7:0] crc;
		res_exp = '{TEMP[7:0], TEMP[15:8], 8'h4B, 8'h46, 8'hFF, 8'hFF,
			REMAIN, 8'h10, 8'h00};
		crc = 8'h00;
		for (int i = 0; i < 8; i++)
			for (int j = 0; j < 8; j++)
				crc = (crc >> 1) ^
					((crc[0] ^ res_exp[i][j]) ? 8'h8C : 8'h00);
		res_exp[8] = crc;
		issue(owr_pkg::OWR_OP_READ);
		wait_done(70000);
		chk_cmd(8'hBE);
		chk("slot count", 89, bits_q.size());
		// first four taken with a stall cycle between takes
		for (int i = 0; i < 4; i++) begin
			chk("result valid", 1, out_valid);
			chk("result byte", res_exp[i], out_data);
			@(posedge mclk);
			#5;
			out_ready = 1'b1;
			@(posedge mclk);
			#5;
			out_ready = 1'b0;
		end
		chk("result left", 1, out_valid);
		$display("test scratchpad read finished");
	endtask

	// rest of the result taken back to back through the master's port
	task automatic t_fifo();
		repeat (3) @(posedge mclk);
		#5;
		chk("fifo holds", 1, out_valid);
		chk("fifo head", res_exp[4], out_data);
		out_ready = 1'b1;
		for (int i = 4; i < 9; i++) begin
			chk("fifo valid", 1, out_valid);
			chk("fifo word", res_exp[i], out_data);
			@(posedge mclk);
			#5;
		end
		out_ready = 1'b0;
		chk("fifo drained", 0, out_valid);
		chk("fifo ready", 1, cmd_ready);
		$display("test fifo finished");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		#5;
		reset_n = 1'b1;
		fork
			conversion_duration();
			t_lone();
		join
		t_read();
		t_fifo();
		print_verdict();
	end

	// the tests need about 85000 cycles
	initial begin
		repeat (100000) @(posedge mclk);
		num_errors++;
		$display("BAD watchdog expected finish seen timeout");
		print_verdict();
	end
endmodule

//--- sim/owr_link_properties.sv
/*
 Checker for the single-wire link: slot, presence and pullup timing.
 Assumes the interface signals of the master/sensor pair on a 10 MHz mclk.
*/
module owr_link_checker #(
	parameter int CONV_CYC = 2000
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic m_dq_o,
	input wire logic m_dq_oe_n,
	input wire logic s_dq_o,
	input wire logic s_dq_oe_n,
	input wire logic spu,
	input wire logic dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] m_low_cnt;
	logic [12:0] since_fall;
	logic [12:0] since_rel;
	logic [11:0] s_low_cnt;
	logic [31:0] spu_cnt;
	logic        m_oe_n_d;

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// saturate high so the first fall after reset is not mistaken for a slot
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			m_oe_n_d   <= 1'b1;
			m_low_cnt  <= 13'h0;
			since_fall <= 13'h1FFF;
			since_rel  <= 13'h1FFF;
		end else begin
			m_oe_n_d  <= m_dq_oe_n;
			m_low_cnt <= m_dq_oe_n ? 13'h0 : m_low_cnt + 13'h1;
			if (m_oe_n_d && !m_dq_oe_n)
				since_fall <= 13'h0;
			else if (since_fall != 13'h1FFF)
				since_fall <= since_fall + 13'h1;
			if (!m_oe_n_d && m_dq_oe_n)
				since_rel <= 13'h0;
			else if (since_rel != 13'h1FFF)
				since_rel <= since_rel + 13'h1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			s_low_cnt <= 12'h0;
		else
			s_low_cnt <= s_dq_oe_n ? 12'h0 : s_low_cnt + 12'h1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			spu_cnt <= 32'h0;
		else
			spu_cnt <= spu ? spu_cnt + 32'h1 : 32'h0;
	end

	a_sensor_slot_only: assert property ($fell(s_dq_oe_n) |->
		since_fall <= 13'h2 || since_fall > 13'hFA0)
		else $error("sensor drove outside a slot or presence");
	a_zero_hold_valid: assert property (
		$rose(s_dq_oe_n) && since_fall < 13'hFA0 |->
		since_fall >= 13'h94 && since_fall < 13'h258)
		else $error("sensor zero released too early or too late");
	a_presence_wait: assert property (
		$fell(s_dq_oe_n) && since_fall > 13'hFA0 |->
		since_rel >= 13'h96 && since_rel <= 13'h258)
		else $error("presence started outside its wait window");
	a_presence_len: assert property (
		$rose(s_dq_oe_n) && since_fall > 13'hFA0 |->
		s_low_cnt >= 12'h258 && s_low_cnt <= 12'h960)
		else $error("presence pulse length out of range");
	a_init_low_short: assert property (
		$rose(m_dq_oe_n) && m_low_cnt < 13'h258 |->
		m_low_cnt >= 13'hA && m_low_cnt < 13'h96)
		else $error("slot opening low of wrong length");
	a_reset_low_min: assert property (
		$rose(m_dq_oe_n) && m_low_cnt > 13'h258 |-> m_low_cnt >= 13'h12C0)
		else $error("reset pulse too short");
	a_slot_spacing: assert property ($fell(m_dq_oe_n) |->
		since_fall >= 13'h261)
		else $error("slots closer than length plus recovery");
	a_spu_quiet: assert property (spu |-> m_dq_oe_n && s_dq_oe_n)
		else $error("line driven under strong pullup");
	a_spu_length: assert property ($fell(spu) |->
		spu_cnt == 32'(CONV_CYC))
		else $error("strong pullup length differs from conversion time");
endmodule
